/* hdl/sfmf_top.sv */
// sample buffer, buffer modes and motion event flags of a three-axis sensor
// assumes: register port from serial interface logic on clk; samples and tap level from the
// sensing chain on clk with one-cycle sample_valid; reg_rd/reg_wr are one-cycle strobes
`timescale 1ns/10ps
module sfmf_top #(
  parameter int SW = 16,
  parameter int DEPTH = sfmf_pkg::BUFFER_DEPTH,
  parameter int SEC_CYC = sfmf_pkg::SEC_CYCLES,
  parameter int FALL_CYC = sfmf_pkg::FALL_CYCLES,
  parameter int TAPD_CYC = sfmf_pkg::TAP_DUR_CYCLES,
  parameter int TAPLW_CYC = sfmf_pkg::TAP_LW_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [SW-1:0] x_in,
  input wire logic [SW-1:0] y_in,
  input wire logic [SW-1:0] z_in,
  input wire logic [SW-1:0] x_ac,
  input wire logic [SW-1:0] y_ac,
  input wire logic [SW-1:0] z_ac,
  input wire logic tap_level,
  output logic irq_out_a,
  output logic irq_out_b
);
  localparam int W = 3*SW;
  localparam int CW = $clog2(DEPTH);
  localparam int TW = 32;
  typedef struct packed {
    logic [7:0] tap_threshold;
    logic [7:0] tap_duration;
    logic [7:0] tap_latency;
    logic [7:0] tap_window;
    logic [7:0] activity_threshold;
    logic [7:0] stillness_threshold;
    logic [7:0] stillness_time;
    logic [7:0] motion_axis_control;
    logic [7:0] fall_threshold;
    logic [7:0] fall_time;
    logic [7:0] event_enable;
    logic [7:0] event_map;
    logic [7:0] buffer_control;
    logic [5:0] src;
    logic [W-1:0] out_regs;
    logic unread;
    logic triggered;
    logic trimming;
    logic [TW-1:0] still_cyc;
    logic [7:0] still_sec;
    logic [TW-1:0] fall_cyc;
    logic [7:0] fall_units;
    logic [1:0] tap_st;
    logic [TW-1:0] tap_cyc;
    logic [7:0] tap_units;
    logic [7:0] rdata;
    logic irq_a;
    logic irq_b;
  } sfmf_state_t;
  sfmf_state_t s_q, s_d;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, f_flush, f_drop;
  logic [W-1:0] f_out_data;
  logic [CW:0] f_count;
  logic [7:0] ev_raw;
  sfmf_pkg::sfmf_mode_t mode;
  logic [CW:0] n_keep;
  logic sample_rd, trig_src, act_hit, still_hit, fall_hit, full_now;
  function automatic logic [SW-1:0] mag(input logic [SW-1:0] v);
    mag = v[SW-1] ? (~v + 1'b1) : v;
  endfunction : mag
  function automatic logic over(input logic [SW-1:0] v, input logic [7:0] th);
    over = mag(v) > {{(SW-8){1'b0}}, th};
  endfunction : over
  assign mode = sfmf_pkg::sfmf_mode_t'(s_q.buffer_control[sfmf_pkg::MODE_HI:sfmf_pkg::MODE_LO]);
  assign n_keep = (CW+1)'(s_q.buffer_control[sfmf_pkg::COUNT_HI:0]);
  assign sample_rd = reg_rd && reg_addr == sfmf_pkg::ADDR_SAMPLE_FIRST;
  // in fifo mode and after a trigger, a full buffer refuses new samples
  assign f_in_valid = sample_valid && mode != sfmf_pkg::SFMF_BYPASS && !s_q.trimming;
  assign f_drop = (s_q.trimming && f_count > n_keep)
    || (sample_valid && !f_in_ready && (mode == sfmf_pkg::SFMF_STREAM
      || (mode == sfmf_pkg::SFMF_TRIGGER && !s_q.triggered)));
  assign f_out_ready = sample_rd && mode != sfmf_pkg::SFMF_BYPASS;
  assign f_flush = mode == sfmf_pkg::SFMF_BYPASS;
  assign full_now = sample_valid && f_in_valid && f_count == (CW+1)'(DEPTH - 1);
  sfmf_fifo #(.WIDTH(W), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .flush(f_flush),
    .drop(f_drop),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data({x_in, y_in, z_in}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data),
    .count(f_count)
  );
  // any enabled axis above the activity threshold, ac-coupled values
  assign act_hit = (s_q.motion_axis_control[sfmf_pkg::ACT_EN_LO+2] && over(x_ac, s_q.activity_threshold))
    || (s_q.motion_axis_control[sfmf_pkg::ACT_EN_LO+1] && over(y_ac, s_q.activity_threshold))
    || (s_q.motion_axis_control[sfmf_pkg::ACT_EN_LO] && over(z_ac, s_q.activity_threshold));
  // all enabled axes below; with no axis enabled nothing counts
  assign still_hit = (s_q.motion_axis_control[sfmf_pkg::INACT_EN_LO+2:sfmf_pkg::INACT_EN_LO] != 3'b000)
    && !(s_q.motion_axis_control[sfmf_pkg::INACT_EN_LO+2] && over(x_ac, s_q.stillness_threshold))
    && !(s_q.motion_axis_control[sfmf_pkg::INACT_EN_LO+1] && over(y_ac, s_q.stillness_threshold))
    && !(s_q.motion_axis_control[sfmf_pkg::INACT_EN_LO] && over(z_ac, s_q.stillness_threshold));
  // raw dc values, all axes anded, no axis enables consulted
  assign fall_hit = !over(x_in, s_q.fall_threshold) && !over(y_in, s_q.fall_threshold)
    && !over(z_in, s_q.fall_threshold);
  always_comb begin
    ev_raw = 8'h00;
    ev_raw[sfmf_pkg::EV_WMARK] = f_count == n_keep && mode != sfmf_pkg::SFMF_BYPASS;
    ev_raw[sfmf_pkg::EV_OVRN] = s_q.src[sfmf_pkg::EV_OVRN];
  end
  // trigger source is the selected irq output
  assign trig_src = s_q.buffer_control[sfmf_pkg::TRIG_SEL_BIT] ? s_q.irq_b : s_q.irq_a;
  always_comb begin
    s_d = s_q;
    s_d.src[sfmf_pkg::EV_WMARK] = (f_count >= n_keep) && (n_keep != '0)
      && mode != sfmf_pkg::SFMF_BYPASS;
    if (reg_rd && reg_addr == sfmf_pkg::ADDR_EVENT_SOURCE) begin
      s_d.src[sfmf_pkg::EV_DTAP] = 1'b0;
      s_d.src[sfmf_pkg::EV_ACT] = 1'b0;
      s_d.src[sfmf_pkg::EV_INACT] = 1'b0;
      s_d.src[sfmf_pkg::EV_FALL] = 1'b0;
    end
    if (sample_rd) begin
      s_d.unread = 1'b0;
      s_d.src[sfmf_pkg::EV_OVRN] = 1'b0;
      if (mode == sfmf_pkg::SFMF_BYPASS) s_d.out_regs = s_q.out_regs;
      else if (f_out_valid) s_d.out_regs = f_out_data;
    end
    if (sample_valid) begin
      if (mode == sfmf_pkg::SFMF_BYPASS) begin
        if (s_q.unread) s_d.src[sfmf_pkg::EV_OVRN] = 1'b1;
        s_d.out_regs = {x_in, y_in, z_in};
        s_d.unread = 1'b1;
      end else if (full_now || (!f_in_ready && mode != sfmf_pkg::SFMF_FIFO && !s_q.triggered)) begin
        s_d.src[sfmf_pkg::EV_OVRN] = 1'b1;
      end
      // detectors run in every mode regardless of buffer state
      if (act_hit) s_d.src[sfmf_pkg::EV_ACT] = 1'b1;
      if (still_hit) begin
        s_d.still_cyc = s_q.still_cyc;
      end else begin
        s_d.still_cyc = '0;
        s_d.still_sec = '0;
      end
      if (!fall_hit) begin
        s_d.fall_cyc = '0;
        s_d.fall_units = '0;
      end
    end
    // seconds counted while still; flag once count passes the setting
    if (still_hit && s_q.still_sec <= s_q.stillness_time) begin
      if (s_q.still_cyc == TW'(SEC_CYC - 1)) begin
        s_d.still_cyc = '0;
        s_d.still_sec = s_q.still_sec + 8'h01;
      end else begin
        s_d.still_cyc = s_q.still_cyc + 1'b1;
      end
    end
    if (still_hit && s_q.still_sec > s_q.stillness_time) s_d.src[sfmf_pkg::EV_INACT] = 1'b1;
    // fall timer in 5 ms units
    if (fall_hit && s_q.fall_units <= s_q.fall_time) begin
      if (s_q.fall_cyc == TW'(FALL_CYC - 1)) begin
        s_d.fall_cyc = '0;
        s_d.fall_units = s_q.fall_units + 8'h01;
      end else begin
        s_d.fall_cyc = s_q.fall_cyc + 1'b1;
      end
    end
    if (fall_hit && s_q.fall_units > s_q.fall_time) s_d.src[sfmf_pkg::EV_FALL] = 1'b1;
    // 0 idle, 1 first tap high, 2 latency/window, 3 second tap high
    s_d.tap_cyc = s_q.tap_cyc + 1'b1;
    if (s_q.tap_cyc == TW'((s_q.tap_st[0] ? TAPD_CYC : TAPLW_CYC) - 1)) begin
      s_d.tap_cyc = '0;
      s_d.tap_units = s_q.tap_units + 8'h01;
    end
    case (s_q.tap_st)
      2'd0: begin
        s_d.tap_cyc = '0;
        s_d.tap_units = '0;
        if (tap_level) s_d.tap_st = 2'd1;
      end
      2'd1: begin
        if (s_q.tap_units >= s_q.tap_duration) s_d.tap_st = 2'd0;
        else if (!tap_level) begin
          s_d.tap_st = 2'd2;
          s_d.tap_cyc = '0;
          s_d.tap_units = '0;
        end
      end
      2'd2: begin
        if (s_q.tap_units >= s_q.tap_window) s_d.tap_st = 2'd0;
        else if (tap_level) begin
          s_d.tap_st = (s_q.tap_units >= s_q.tap_latency) ? 2'd3 : 2'd0;
          s_d.tap_cyc = '0;
          s_d.tap_units = '0;
        end
      end
      2'd3: begin
        if (s_q.tap_units >= s_q.tap_duration) s_d.tap_st = 2'd0;
        else if (!tap_level) begin
          s_d.tap_st = 2'd0;
          s_d.src[sfmf_pkg::EV_DTAP] = 1'b1;
        end
      end
      default: s_d.tap_st = 2'd0;
    endcase
    // first trigger only; trimming runs until n remain
    if (mode == sfmf_pkg::SFMF_TRIGGER && !s_q.triggered && trig_src) begin
      s_d.triggered = 1'b1;
      s_d.trimming = 1'b1;
    end
    if (s_q.trimming && f_count <= n_keep) s_d.trimming = 1'b0;
    if (mode != sfmf_pkg::SFMF_TRIGGER) begin
      s_d.triggered = 1'b0;
      s_d.trimming = 1'b0;
    end
    // enabled flags routed by the map bit
    s_d.irq_a = |(s_d.src & s_q.event_enable[5:0] & ~s_q.event_map[5:0]);
    s_d.irq_b = |(s_d.src & s_q.event_enable[5:0] & s_q.event_map[5:0]);
    if (reg_wr) begin
      case (reg_addr)
        sfmf_pkg::ADDR_TAP_THRESHOLD: s_d.tap_threshold = reg_wdata;
        sfmf_pkg::ADDR_TAP_DURATION: s_d.tap_duration = reg_wdata;
        sfmf_pkg::ADDR_TAP_LATENCY: s_d.tap_latency = reg_wdata;
        sfmf_pkg::ADDR_TAP_WINDOW: s_d.tap_window = reg_wdata;
        sfmf_pkg::ADDR_ACTIVITY_THRESHOLD: s_d.activity_threshold = reg_wdata;
        sfmf_pkg::ADDR_STILLNESS_THRESHOLD: s_d.stillness_threshold = reg_wdata;
        sfmf_pkg::ADDR_STILLNESS_TIME: s_d.stillness_time = reg_wdata;
        sfmf_pkg::ADDR_MOTION_AXIS_CONTROL: s_d.motion_axis_control = reg_wdata;
        sfmf_pkg::ADDR_FALL_THRESHOLD: s_d.fall_threshold = reg_wdata;
        sfmf_pkg::ADDR_FALL_TIME: s_d.fall_time = reg_wdata;
        sfmf_pkg::ADDR_EVENT_ENABLE: s_d.event_enable = reg_wdata;
        sfmf_pkg::ADDR_EVENT_MAP: s_d.event_map = reg_wdata;
        sfmf_pkg::ADDR_BUFFER_CONTROL: s_d.buffer_control = reg_wdata;
        default: s_d.event_map = s_d.event_map;
      endcase
    end
    // read data is registered: it appears the cycle after reg_rd
    case (reg_addr)
      sfmf_pkg::ADDR_TAP_THRESHOLD: s_d.rdata = s_q.tap_threshold;
      sfmf_pkg::ADDR_TAP_DURATION: s_d.rdata = s_q.tap_duration;
      sfmf_pkg::ADDR_TAP_LATENCY: s_d.rdata = s_q.tap_latency;
      sfmf_pkg::ADDR_TAP_WINDOW: s_d.rdata = s_q.tap_window;
      sfmf_pkg::ADDR_ACTIVITY_THRESHOLD: s_d.rdata = s_q.activity_threshold;
      sfmf_pkg::ADDR_STILLNESS_THRESHOLD: s_d.rdata = s_q.stillness_threshold;
      sfmf_pkg::ADDR_STILLNESS_TIME: s_d.rdata = s_q.stillness_time;
      sfmf_pkg::ADDR_MOTION_AXIS_CONTROL: s_d.rdata = s_q.motion_axis_control;
      sfmf_pkg::ADDR_FALL_THRESHOLD: s_d.rdata = s_q.fall_threshold;
      sfmf_pkg::ADDR_FALL_TIME: s_d.rdata = s_q.fall_time;
      sfmf_pkg::ADDR_EVENT_ENABLE: s_d.rdata = s_q.event_enable;
      sfmf_pkg::ADDR_EVENT_MAP: s_d.rdata = s_q.event_map;
      sfmf_pkg::ADDR_EVENT_SOURCE: s_d.rdata = {2'b00, s_q.src};
      sfmf_pkg::ADDR_BUFFER_CONTROL: s_d.rdata = s_q.buffer_control;
      sfmf_pkg::ADDR_BUFFER_STATUS: s_d.rdata = {s_q.triggered, 1'b0, 6'(f_count)};
      6'h32: s_d.rdata = s_q.out_regs[W-SW +: 8];
      6'h33: s_d.rdata = s_q.out_regs[W-SW+8 +: 8];
      6'h34: s_d.rdata = s_q.out_regs[SW +: 8];
      6'h35: s_d.rdata = s_q.out_regs[SW+8 +: 8];
      6'h36: s_d.rdata = s_q.out_regs[0 +: 8];
      6'h37: s_d.rdata = s_q.out_regs[8 +: 8];
      default: s_d.rdata = sfmf_pkg::RESET_BYTE;
    endcase
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  assign reg_rdata = s_q.rdata;
  assign irq_out_a = s_q.irq_a;
  assign irq_out_b = s_q.irq_b;
  // tap threshold is applied upstream in the sensing chain that makes tap_level
  logic unused_ok;
  assign unused_ok = ^{s_q.tap_threshold, ev_raw};

  bypass_empty_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && mode == sfmf_pkg::SFMF_BYPASS |=> f_count == '0) else $error("buffer not empty in bypass");
  fifo_cap_a: assert property (@(posedge clk) disable iff (!nrst)
    f_count <= (CW+1)'(DEPTH)) else $error("buffer over depth");
  fifo_stop_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && mode == sfmf_pkg::SFMF_FIFO && f_count == (CW+1)'(DEPTH) && !f_out_ready
    |=> f_count == (CW+1)'(DEPTH)) else $error("fifo mode changed a full buffer");
  wmark_set_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && mode != sfmf_pkg::SFMF_BYPASS && n_keep != '0 && f_count == n_keep
    |=> s_q.src[sfmf_pkg::EV_WMARK]) else $error("watermark not set");
  wmark_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && f_count < n_keep |=> !s_q.src[sfmf_pkg::EV_WMARK]) else $error("watermark stuck");
  ovr_clr_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && sample_rd && !sample_valid |=> !s_q.src[sfmf_pkg::EV_OVRN]) else $error("overrun not cleared");
  ovr_bypass_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && mode == sfmf_pkg::SFMF_BYPASS && sample_valid && s_q.unread
    |=> s_q.src[sfmf_pkg::EV_OVRN]) else $error("bypass overrun missed");
  irq_gate_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_q.event_enable[5:0] == 6'h00 |=> !irq_out_a && !irq_out_b) else $error("disabled irq fired");
  trig_once_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && s_q.triggered && mode == sfmf_pkg::SFMF_TRIGGER |=> s_q.triggered) else $error("trigger rearmed");
endmodule : sfmf_top

/* shared/sfmf_pkg.sv */
// constants for the sample buffer and motion flag block
// assumes a byte-wide register port driven by the serial interface logic on clk
package sfmf_pkg;
  localparam logic [5:0] ADDR_TAP_THRESHOLD = 6'h1D;
  localparam logic [5:0] ADDR_TAP_DURATION = 6'h21;
  localparam logic [5:0] ADDR_TAP_LATENCY = 6'h22;
  localparam logic [5:0] ADDR_TAP_WINDOW = 6'h23;
  localparam logic [5:0] ADDR_ACTIVITY_THRESHOLD = 6'h24;
  localparam logic [5:0] ADDR_STILLNESS_THRESHOLD = 6'h25;
  localparam logic [5:0] ADDR_STILLNESS_TIME = 6'h26;
  localparam logic [5:0] ADDR_MOTION_AXIS_CONTROL = 6'h27;
  localparam logic [5:0] ADDR_FALL_THRESHOLD = 6'h28;
  localparam logic [5:0] ADDR_FALL_TIME = 6'h29;
  localparam logic [5:0] ADDR_EVENT_ENABLE = 6'h2E;
  localparam logic [5:0] ADDR_EVENT_MAP = 6'h2F;
  localparam logic [5:0] ADDR_EVENT_SOURCE = 6'h30;
  localparam logic [5:0] ADDR_SAMPLE_FIRST = 6'h32;
  localparam logic [5:0] ADDR_SAMPLE_LAST = 6'h37;
  localparam logic [5:0] ADDR_BUFFER_CONTROL = 6'h38;
  localparam logic [5:0] ADDR_BUFFER_STATUS = 6'h39;
  // buffer_control fields
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int TRIG_SEL_BIT = 5;
  localparam int COUNT_HI = 4;
  // event bit positions in enable, map and source
  localparam int EV_DTAP = 5;
  localparam int EV_ACT = 4;
  localparam int EV_INACT = 3;
  localparam int EV_FALL = 2;
  localparam int EV_WMARK = 1;
  localparam int EV_OVRN = 0;
  // motion_axis_control: activity enables 6:4, stillness enables 2:0
  localparam int ACT_EN_LO = 4;
  localparam int INACT_EN_LO = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int BUFFER_DEPTH = 32;
  // timer ticks: stillness counts seconds, fall counts 5 ms units
  localparam int CLK_HZ = 50000000;
  localparam int SEC_MS = 1000;
  localparam int FALL_LSB_MS = 5;
  localparam int TAP_LSB_US = 625;
  localparam int TAP_LATWIN_LSB_MS = 1;
  localparam int SEC_CYCLES = CLK_HZ;
  localparam int FALL_CYCLES = CLK_HZ / SEC_MS * FALL_LSB_MS;
  localparam int TAP_DUR_CYCLES = CLK_HZ / SEC_MS / SEC_MS * TAP_LSB_US;
  localparam int TAP_LW_CYCLES = CLK_HZ / SEC_MS * TAP_LATWIN_LSB_MS;
  typedef enum logic [1:0] {
    SFMF_BYPASS = 2'b00,
    SFMF_FIFO = 2'b01,
    SFMF_STREAM = 2'b10,
    SFMF_TRIGGER = 2'b11
  } sfmf_mode_t;
endpackage : sfmf_pkg

/* hdl/sfmf_fifo.sv */
// sample buffer with valid/ready on both sides and a drop-oldest port
// assumes a single clock domain; ce freezes all state
`timescale 1ns/10ps
module sfmf_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic flush,
  input wire logic drop,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [AW:0] cnt;
  } sfmf_fifo_t;
  sfmf_fifo_t s_q, s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;
  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = mem[s_q.rd];
  assign count = s_q.cnt;
  // a drop frees the oldest slot in the same cycle, so a full buffer can still take the new word
  assign push = in_valid && (in_ready || drop);
  assign pop = (out_valid && out_ready) || (drop && out_valid);
  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d = '0;
    end else begin
      if (push) s_d.wr = s_q.wr + 1'b1;
      if (pop) s_d.rd = s_q.rd + 1'b1;
      if (push && !pop) s_d.cnt = s_q.cnt + 1'b1;
      if (pop && !push) s_d.cnt = s_q.cnt - 1'b1;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  always_ff @(posedge clk) begin
    if (ce && push && !flush) mem[s_q.wr] <= in_data;
  end
endmodule : sfmf_fifo

/* testbench/sfmf_host.sv */
// host register master model for the sample buffer block
// assumes the block takes one-cycle strobes on the rising edge of clk
`timescale 1ns/10ps
module sfmf_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // stale data must not look like a held write value
    reg_wdata = ~d;
  endtask : wr
  // byte taken the cycle after the strobe: a source read clears flags on that same edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : sfmf_host

/* testbench/sfmf_top_tb.sv */
// self-checking bench for the sample buffer and motion flag block
// assumes sfmf_host as register master; ac inputs and tap level driven by the bench
`timescale 1ns/10ps
module sfmf_top_tb;
  logic clk;
  logic nrst;
  logic sample_valid;
  logic [15:0] x_in;
  logic [15:0] y_in;
  logic [15:0] z_in;
  logic reg_wr;
  logic reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic irq_out_a;
  logic irq_out_b;
  logic ce;
  logic tap_level;
  logic [15:0] x_ac;
  logic [15:0] y_ac;
  logic [15:0] z_ac;
  int mismatches;
  int samples_checked;
  int cycles;

  // short timer parameters keep the run brief
  sfmf_top #(.SEC_CYC(4), .FALL_CYC(4), .TAPD_CYC(4), .TAPLW_CYC(4)) sfmf_top_inst (
    .clk(clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_valid(sample_valid), .x_in(x_in),
    .y_in(y_in), .z_in(z_in), .x_ac(x_ac), .y_ac(y_ac), .z_ac(z_ac),
    .tap_level(tap_level), .irq_out_a(irq_out_a), .irq_out_b(irq_out_b));
  sfmf_host sfmf_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    sfmf_host_inst.rd(a, rv);
    check(rv, exp);
  endtask : rd_chk
  // the popped sample lands one cycle late, so its high x byte is read after
  task automatic pop_chk(input logic [7:0] exp);
    sfmf_host_inst.rd(6'h32, rv);
    rd_chk(6'h33, exp);
  endtask : pop_chk
  task automatic push(input logic [15:0] x);
    @(negedge clk);
    x_in = x;
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask : push
  task automatic push_run(input int first, input int n);
    for (int i = 0; i < n; i++) begin
      push({8'(first + i), 8'h00});
    end
  endtask : push_run

  task automatic test_regs();
    rd_chk(6'h38, 8'h00);
    sfmf_host_inst.wr(6'h3F, 8'h55);
    rd_chk(6'h3F, 8'h00);
    sfmf_host_inst.wr(6'h21, 8'hA5);
    rd_chk(6'h21, 8'hA5);
  endtask : test_regs
  task automatic test_fifo();
    sfmf_host_inst.wr(6'h27, 8'h40);
    sfmf_host_inst.wr(6'h2E, 8'h12);
    sfmf_host_inst.wr(6'h38, 8'h45);
    push_run(1, 5);
    repeat (3) @(negedge clk);
    check({7'h00, irq_out_a}, 8'h01);
    check({7'h00, irq_out_b}, 8'h00);
    rd_chk(6'h30, 8'h02);
    sfmf_host_inst.wr(6'h2F, 8'h02);
    repeat (3) @(negedge clk);
    check({7'h00, irq_out_b}, 8'h01);
    pop_chk(8'h01);
    rd_chk(6'h30, 8'h00);
    check({7'h00, irq_out_b}, 8'h00);
    push_run(6, 28);
    rd_chk(6'h39, 8'h20);
    rd_chk(6'h30, 8'h03);
    sfmf_host_inst.wr(6'h24, 8'h10);
    x_ac = 16'h0020;
    push(16'h2240);
    x_ac = 16'h0000;
    rd_chk(6'h39, 8'h20);
    rd_chk(6'h30, 8'h13);
    rd_chk(6'h30, 8'h03);
    pop_chk(8'h02);
    rd_chk(6'h30, 8'h02);
    rd_chk(6'h39, 8'h1F);
  endtask : test_fifo
  task automatic test_bypass();
    sfmf_host_inst.wr(6'h38, 8'h00);
    rd_chk(6'h39, 8'h00);
    push(16'h0A00);
    push(16'h0B00);
    rd_chk(6'h39, 8'h00);
    rd_chk(6'h30, 8'h01);
    rd_chk(6'h33, 8'h0B);
  endtask : test_bypass
  task automatic test_stream();
    sfmf_host_inst.wr(6'h38, 8'h80);
    push_run(1, 33);
    rd_chk(6'h39, 8'h20);
    pop_chk(8'h02);
  endtask : test_stream
  // activity on x raises irq_out_a, which is the selected trigger; n = 2
  task automatic test_trigger();
    sfmf_host_inst.wr(6'h38, 8'h00);
    sfmf_host_inst.wr(6'h38, 8'hC2);
    push_run(1, 4);
    x_ac = 16'h0020;
    push(16'h0500);
    x_ac = 16'h0000;
    repeat (10) @(negedge clk);
    rd_chk(6'h39, 8'h82);
    pop_chk(8'h04);
  endtask : test_trigger

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // generous ceiling: the whole sequence needs well under 2000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    nrst = 1'b0;
    sample_valid = 1'b0;
    ce = 1'b1;
    tap_level = 1'b0;
    x_ac = 16'h0000;
    y_ac = 16'h0000;
    z_ac = 16'h0000;
    // nonzero x keeps the fall detector quiet while flags are compared
    x_in = 16'h0100;
    y_in = 16'h0000;
    z_in = 16'h0000;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    test_regs();
    test_fifo();
    test_bypass();
    test_stream();
    test_trigger();
    tally_and_finish();
  end
endmodule : sfmf_top_tb
